// File: design/amd_params.svh
/*
 Timing counts, field positions and reset values for the ALU and multiply datapath.
 Included by its bare name from the package, the working register array and the ALU core.
*/
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH
`define AMD_WORD_W 16
`define AMD_REG_COUNT 16
`define AMD_FLAG_C 0
`define AMD_FLAG_Z 1
`define AMD_FLAG_N 2
`define AMD_FLAG_OV 3
`define AMD_FLAG_DC 4
`define AMD_STATUS_RESET 5'h00
`define AMD_DIV_STEPS 5'h10
`endif

// File: design/amd_pkg.sv
/*
 Types shared by the ALU and multiply datapath: operation codes and multiply modes.
 Assumes amd_params.svh is on the include path.
*/
`include "amd_params.svh"
package amd_pkg;
    typedef enum logic [3:0] {
        AMD_OP_ADD, AMD_OP_ADDC, AMD_OP_SUB, AMD_OP_SUBB,
        AMD_OP_AND, AMD_OP_IOR, AMD_OP_XOR, AMD_OP_SHL,
        AMD_OP_LSR, AMD_OP_ASR, AMD_OP_MUL, AMD_OP_DIVU,
        AMD_OP_DIVS, AMD_OP_MOV
    } amd_op_type;
    typedef enum logic [2:0] {
        AMD_MUL_SS, AMD_MUL_UU, AMD_MUL_SL, AMD_MUL_UL,
        AMD_MUL_US, AMD_MUL_BB
    } amd_mul_type;
endpackage

// File: design/amd_regfile_if.sv
/*
 Read and write ports of the working register array, between the top and the array.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface amd_regfile_if;
    logic [3:0] readAddrA;
    logic [3:0] readAddrB;
    logic [15:0] readDataA;
    logic [15:0] readDataB;
    logic writeEn;
    logic writeByte;
    logic [3:0] writeAddr;
    logic [15:0] writeData;
    modport user (output readAddrA, readAddrB, writeEn, writeByte, writeAddr, writeData,
        input readDataA, readDataB);
    modport array (input readAddrA, readAddrB, writeEn, writeByte, writeAddr, writeData,
        output readDataA, readDataB);
endinterface
`default_nettype wire

// File: design/amd_working_regs.sv
/*
 Working register array of sixteen 16-bit registers, two read ports, one write port.
 Assumes a synchronous reset copy from the top; byte writes touch the low byte only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"
module amd_working_regs
    import amd_pkg::*;
(
    input wire logic clk,
    input wire logic rstSync_b,
    amd_regfile_if.array rf
);
    logic [15:0] regs [`AMD_REG_COUNT];
    logic [15:0] next_regs [`AMD_REG_COUNT];

    // Combinational read, so an operand fetched this cycle is used this cycle
    assign rf.readDataA = regs[rf.readAddrA];
    assign rf.readDataB = regs[rf.readAddrB];

    ////////////////////////////////////////////////////////////////////////////////
    // One entry per register, each with its own write decode
    genvar gi;
    generate
        for (gi = 0; gi < `AMD_REG_COUNT; gi++) begin : g_reg
            always_comb begin
                next_regs[gi] = regs[gi];
                if (rf.writeEn && rf.writeAddr == 4'(gi)) begin
                    if (rf.writeByte) begin
                        next_regs[gi] = {regs[gi][15:8], rf.writeData[7:0]};
                    end else begin
                        next_regs[gi] = rf.writeData;
                    end
                end
            end
            always_ff @(posedge clk or negedge rstSync_b) begin
                if (!rstSync_b) begin
                    regs[gi] <= 16'h0000;
                end else begin
                    regs[gi] <= next_regs[gi];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: design/amd_multiplier.sv
/*
 17x17 signed array multiplier; each operand is extended to 17 bits so every sign mix
 maps to one signed product. Purely combinational; the top registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module amd_multiplier
    import amd_pkg::*;
(
    input wire logic [15:0] opA,
    input wire logic [15:0] opB,
    input wire logic [4:0] literal,
    input var amd_mul_type mode,
    output logic [31:0] product
);
    logic signed [16:0] extA;
    logic signed [16:0] extB;
    logic signed [33:0] full;

    // Extension bit chosen per mode: sign for signed operands, zero otherwise
    always_comb begin
        extA = {1'b0, opA};
        extB = {1'b0, opB};
        unique case (mode)
            AMD_MUL_SS: begin
                extA = {opA[15], opA};
                extB = {opB[15], opB};
            end
            AMD_MUL_UU: begin
            end
            AMD_MUL_SL: begin
                extA = {opA[15], opA};
                extB = {12'h000, literal};
            end
            AMD_MUL_UL: begin
                extB = {12'h000, literal};
            end
            AMD_MUL_US: begin
                extB = {opB[15], opB};
            end
            AMD_MUL_BB: begin
                extA = {9'h000, opA[7:0]};
                extB = {9'h000, opB[7:0]};
            end
            default: begin
            end
        endcase
    end

    // One signed array serves every mode
    assign full = extA * extB;
    assign product = full[31:0];
endmodule
`default_nettype wire

// File: design/amd_alu_core.sv
/*
 16-bit ALU with multiplier, iterative divider, working register array and status flags.
 Assumes the instruction decoder holds issue for one cycle per operation and waits on
 busy for divides; inputs are synchronous to clk.
*/
// How it works
// - The datapath is 16 bits and does add, subtract, shifts and bitwise logic.
// - Arithmetic treats operands and results as two's complement values.
// - Each operation updates carry, zero, negative, overflow and digit carry as it needs.
// - On subtraction carry means no borrow and digit carry means no digit borrow.
// - Each operation except multiply and divide runs in byte or word width as the instruction selects.
// - Operands come from the working register array or from data memory.
// - Results go to the working register array or to a data memory location.
// - There is a hardware multiplier and a divider for a 16-bit divisor.
// - The multiplier is one 17 by 17 array for all sign mixes.
// - Word products are signed by signed, unsigned by unsigned or unsigned by signed.
// - A signed or unsigned word can be multiplied by a 5-bit unsigned literal.
// - An unsigned byte by byte product is supported.
// - The working register array holds sixteen registers numbered zero to fifteen.
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"
module amd_alu_core
    import amd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic issue,
    input var amd_op_type op,
    input var amd_mul_type mulMode,
    input wire logic byteMode,
    input wire logic [3:0] srcAReg,
    input wire logic [3:0] srcBReg,
    input wire logic srcAFromMem,
    input wire logic srcBFromMem,
    input wire logic [15:0] memDataA,
    input wire logic [15:0] memDataB,
    input wire logic [4:0] literal,
    input wire logic [3:0] dstReg,
    input wire logic dstToMem,
    input wire logic flagsWrite,
    output logic [15:0] result,
    output logic [15:0] resultHigh,
    output logic memWrite,
    output logic memWriteByte,
    output logic done,
    output logic busy,
    output logic [4:0] alu_status_register
);
    typedef enum logic [1:0] {AMD_IDLE, AMD_DIV, AMD_FIN} amd_state_type;

    amd_regfile_if rf();
    logic rstMeta_b;
    logic rstSync_b;
    amd_state_type state;
    amd_state_type next_state;
    logic [15:0] opA;
    logic [15:0] opB;
    logic [31:0] product;
    logic [16:0] sumRes;
    logic [4:0] nibSum;
    logic [15:0] logicRes;
    logic [15:0] resVal;
    logic carryOut;
    logic ovfOut;
    logic signBit;
    logic [15:0] next_result;
    logic [15:0] next_resultHigh;
    logic next_memWrite;
    logic next_memWriteByte;
    logic next_done;
    logic [4:0] next_status;
    logic [15:0] divQuot;
    logic [15:0] divRem;
    logic [15:0] divisor;
    logic [4:0] divCnt;
    logic divNegQ;
    logic divNegR;
    logic [3:0] divDst;
    logic divToMem;
    logic [15:0] next_divQuot;
    logic [15:0] next_divRem;
    logic [15:0] next_divisor;
    logic [4:0] next_divCnt;
    logic next_divNegQ;
    logic next_divNegR;
    logic [3:0] next_divDst;
    logic next_divToMem;
    logic [16:0] trial;
    logic [15:0] shiftRem;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; nothing but the second flop reads the first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_b <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_b <= 1'b1;
            rstSync_b <= rstMeta_b;
        end
    end

    amd_working_regs u_regs (
        .clk(clk),
        .rstSync_b(rstSync_b),
        .rf(rf.array)
    );

    amd_multiplier u_mul (
        .opA(opA),
        .opB(opB),
        .literal(literal),
        .mode(mulMode),
        .product(product)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Operand selection: register array or data memory per operand
    assign rf.readAddrA = srcAReg;
    assign rf.readAddrB = srcBReg;
    assign opA = srcAFromMem ? memDataA : rf.readDataA;
    assign opB = srcBFromMem ? memDataB : rf.readDataB;

    // Adder and logic unit; subtraction adds the complement so carry is the inverse of borrow
    always_comb begin
        logic [15:0] addB;
        logic cin;
        addB = opB;
        cin = 1'b0;
        unique case (op)
            AMD_OP_ADDC: cin = alu_status_register[`AMD_FLAG_C];
            AMD_OP_SUB: begin
                addB = ~opB;
                cin = 1'b1;
            end
            AMD_OP_SUBB: begin
                addB = ~opB;
                cin = alu_status_register[`AMD_FLAG_C];
            end
            default: begin
            end
        endcase
        sumRes = {1'b0, opA} + {1'b0, addB} + {16'h0000, cin};
        nibSum = {1'b0, opA[3:0]} + {1'b0, addB[3:0]} + {4'h0, cin};
        unique case (op)
            AMD_OP_AND: logicRes = opA & opB;
            AMD_OP_IOR: logicRes = opA | opB;
            AMD_OP_XOR: logicRes = opA ^ opB;
            AMD_OP_SHL: logicRes = opA << 1;
            AMD_OP_LSR: logicRes = byteMode ? {8'h00, 1'b0, opA[7:1]} : {1'b0, opA[15:1]};
            AMD_OP_ASR: logicRes = byteMode ? {8'h00, opA[7], opA[7:1]} : {opA[15], opA[15:1]};
            default: logicRes = opA;
        endcase
        // Byte mode takes the carry and overflow from bit 7
        if (byteMode) begin
            carryOut = sumRes[8] ^ opA[8] ^ addB[8];
            ovfOut = (opA[7] == addB[7]) && (sumRes[7] != opA[7]);
        end else begin
            carryOut = sumRes[16];
            ovfOut = (opA[15] == addB[15]) && (sumRes[15] != opA[15]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider step: restoring, one quotient bit per cycle on magnitudes
    assign shiftRem = {divRem[14:0], divQuot[15]};
    assign trial = {divRem[15], shiftRem} - {1'b0, divisor};

    // Result, flags, divider and sequencing next values
    always_comb begin
        logic [15:0] absA;
        logic [15:0] absB;
        logic [15:0] q;
        logic [15:0] r;
        logic flagC;
        logic flagOv;
        logic flagDc;
        logic updC;
        absA = (op == AMD_OP_DIVS && opA[15]) ? 16'(-opA) : opA;
        absB = (op == AMD_OP_DIVS && opB[15]) ? 16'(-opB) : opB;
        q = 16'h0000;
        r = 16'h0000;
        next_state = state;
        next_result = result;
        next_resultHigh = resultHigh;
        next_memWrite = 1'b0;
        next_memWriteByte = 1'b0;
        next_done = 1'b0;
        next_status = alu_status_register;
        next_divQuot = divQuot;
        next_divRem = divRem;
        next_divisor = divisor;
        next_divCnt = divCnt;
        next_divNegQ = divNegQ;
        next_divNegR = divNegR;
        next_divDst = divDst;
        next_divToMem = divToMem;
        rf.writeEn = 1'b0;
        rf.writeByte = 1'b0;
        rf.writeAddr = dstReg;
        rf.writeData = 16'h0000;
        resVal = 16'h0000;
        signBit = 1'b0;
        flagC = alu_status_register[`AMD_FLAG_C];
        flagOv = alu_status_register[`AMD_FLAG_OV];
        flagDc = alu_status_register[`AMD_FLAG_DC];
        updC = 1'b0;
        unique case (state)
            AMD_IDLE: begin
                if (issue) begin
                    unique case (op)
                        AMD_OP_ADD, AMD_OP_ADDC, AMD_OP_SUB, AMD_OP_SUBB: begin
                            resVal = sumRes[15:0];
                            flagC = carryOut;
                            flagOv = ovfOut;
                            flagDc = nibSum[4];
                            updC = 1'b1;
                        end
                        AMD_OP_SHL: begin
                            resVal = logicRes;
                            flagC = byteMode ? opA[7] : opA[15];
                            updC = 1'b1;
                        end
                        AMD_OP_LSR, AMD_OP_ASR: begin
                            resVal = logicRes;
                            flagC = opA[0];
                            updC = 1'b1;
                        end
                        AMD_OP_MUL: begin
                            resVal = product[15:0];
                            next_resultHigh = product[31:16];
                        end
                        AMD_OP_DIVU, AMD_OP_DIVS: begin
                            next_state = AMD_DIV;
                            next_divQuot = absA;
                            next_divRem = 16'h0000;
                            next_divisor = absB;
                            next_divCnt = `AMD_DIV_STEPS;
                            next_divNegQ = (op == AMD_OP_DIVS) && (opA[15] ^ opB[15]);
                            next_divNegR = (op == AMD_OP_DIVS) && opA[15];
                            next_divDst = dstReg;
                            next_divToMem = dstToMem;
                        end
                        default: resVal = logicRes;
                    endcase
                    if (op != AMD_OP_DIVU && op != AMD_OP_DIVS) begin
                        if (byteMode && op != AMD_OP_MUL) begin
                            resVal = {8'h00, resVal[7:0]};
                        end
                        signBit = byteMode ? resVal[7] : resVal[15];
                        next_result = resVal;
                        next_done = 1'b1;
                        // Destination: the array, or a memory write strobe
                        rf.writeEn = !dstToMem;
                        rf.writeByte = byteMode && op != AMD_OP_MUL;
                        rf.writeData = resVal;
                        next_memWrite = dstToMem;
                        next_memWriteByte = byteMode && op != AMD_OP_MUL;
                        if (flagsWrite && op != AMD_OP_MUL && op != AMD_OP_MOV) begin
                            next_status[`AMD_FLAG_Z] = (resVal == 16'h0000);
                            next_status[`AMD_FLAG_N] = signBit;
                            if (updC) begin
                                next_status[`AMD_FLAG_C] = flagC;
                            end
                            next_status[`AMD_FLAG_OV] = updC ? flagOv : 1'b0;
                            next_status[`AMD_FLAG_DC] = flagDc;
                        end
                    end
                end
            end
            AMD_DIV: begin
                next_divRem = trial[16] ? shiftRem : trial[15:0];
                next_divQuot = {divQuot[14:0], !trial[16]};
                next_divCnt = divCnt - 5'h01;
                if (divCnt == 5'h01) begin
                    next_state = AMD_FIN;
                end
            end
            AMD_FIN: begin
                // Quotient to result, remainder to the high word; sign restored here
                q = divNegQ ? 16'(-divQuot) : divQuot;
                r = divNegR ? 16'(-divRem) : divRem;
                next_result = q;
                next_resultHigh = r;
                next_done = 1'b1;
                next_state = AMD_IDLE;
                rf.writeAddr = divDst;
                rf.writeEn = !divToMem;
                rf.writeData = q;
                next_memWrite = divToMem;
                if (flagsWrite) begin
                    next_status[`AMD_FLAG_Z] = (q == 16'h0000);
                    next_status[`AMD_FLAG_N] = q[15];
                    next_status[`AMD_FLAG_OV] = (divisor == 16'h0000);
                end
            end
            default: next_state = AMD_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state <= AMD_IDLE;
            result <= 16'h0000;
            resultHigh <= 16'h0000;
            memWrite <= 1'b0;
            memWriteByte <= 1'b0;
            done <= 1'b0;
            busy <= 1'b0;
            alu_status_register <= `AMD_STATUS_RESET;
            divQuot <= 16'h0000;
            divRem <= 16'h0000;
            divisor <= 16'h0000;
            divCnt <= 5'h00;
            divNegQ <= 1'b0;
            divNegR <= 1'b0;
            divDst <= 4'h0;
            divToMem <= 1'b0;
        end else begin
            state <= next_state;
            result <= next_result;
            resultHigh <= next_resultHigh;
            memWrite <= next_memWrite;
            memWriteByte <= next_memWriteByte;
            done <= next_done;
            busy <= (next_state != AMD_IDLE);
            alu_status_register <= next_status;
            divQuot <= next_divQuot;
            divRem <= next_divRem;
            divisor <= next_divisor;
            divCnt <= next_divCnt;
            divNegQ <= next_divNegQ;
            divNegR <= next_divNegR;
            divDst <= next_divDst;
            divToMem <= next_divToMem;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_zero_flag;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && flagsWrite && op == AMD_OP_AND)
            |=> alu_status_register[`AMD_FLAG_Z] == (result == 16'h0000);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

    property p_div_len;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && (op == AMD_OP_DIVU || op == AMD_OP_DIVS))
            |=> busy ##16 (state == AMD_FIN) ##1 done;
    endproperty
    a_div_len: assert property (p_div_len) else $error("divide length wrong");

    property p_byte_high;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && byteMode && op == AMD_OP_XOR)
            |=> result[15:8] == 8'h00;
    endproperty
    a_byte_high: assert property (p_byte_high) else $error("byte result high");

    property p_mem_dst;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && op == AMD_OP_ADD) |=> memWrite == $past(dstToMem);
    endproperty
    a_mem_dst: assert property (p_mem_dst) else $error("memory write strobe wrong");

    property p_sub_borrow;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && flagsWrite && op == AMD_OP_SUB && !byteMode)
            |=> alu_status_register[`AMD_FLAG_C] == ($past(opA) >= $past(opB));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow wrong");

    property p_mul_uu;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && op == AMD_OP_MUL && mulMode == AMD_MUL_UU)
            |=> {resultHigh, result} == $past(opA) * $past(opB);
    endproperty
    a_mul_uu: assert property (p_mul_uu) else $error("unsigned product wrong");

    property p_neg_flag;
        @(posedge clk) disable iff (!rstSync_b)
        (state == AMD_IDLE && issue && flagsWrite && op == AMD_OP_IOR && !byteMode)
            |=> alu_status_register[`AMD_FLAG_N] == result[15];
    endproperty
    a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");

    property p_done_pulse;
        @(posedge clk) disable iff (!rstSync_b)
        done |=> !done || $past(state == AMD_IDLE && issue);
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held");
endmodule
`default_nettype wire

// File: tb/amd_mem_model.sv
/*
 Data memory stand-in on the far side of the datapath: keeps one word, counts stores.
 Assumes memWrite pulses for one clk with result valid; byte stores touch the low byte.
*/
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic memWrite,
    input wire logic memWriteByte,
    input wire logic [15:0] result,
    output logic [15:0] storedWord,
    output logic [7:0] writeCount
);
    // Store on the strobe only, so a missing or extra pulse shows in the count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            storedWord <= 16'h0000;
            writeCount <= 8'h00;
        end else if (memWrite) begin
            storedWord <= memWriteByte ? {storedWord[15:8], result[7:0]} : result;
            writeCount <= writeCount + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: tb/alu_multiply_datapath_tb.sv
/*
 Self-checking bench for amd_alu_core: issues operations and compares results and flags.
 Assumes the one-cycle issue pulse and the busy wait of the hand-over contract.
*/
`timescale 1ns/1ps
`default_nettype none
module alu_multiply_datapath_tb
    import amd_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, issue = 1'b0, byteMode = 1'b0, dstToMem = 1'b0;
    logic srcAFromMem = 1'b1, srcBFromMem = 1'b1, flagsWrite = 1'b1;
    logic [3:0] srcAReg = 4'h0, srcBReg = 4'h0, dstReg = 4'h0;
    logic [15:0] memDataA = 16'h0000, memDataB = 16'h0000, result, resultHigh, storedWord;
    logic [4:0] literal = 5'h00, alu_status_register;
    logic memWrite, memWriteByte, done, busy;
    logic [7:0] writeCount;
    amd_op_type op = AMD_OP_ADD;
    amd_mul_type mulMode = AMD_MUL_SS;
    int nErrors = 0, checksDone = 0, cycles = 0, lat, addLat;
    always #2 clk = ~clk;
    amd_alu_core uut (.clk(clk), .rst_b(rst_b), .issue(issue), .op(op), .mulMode(mulMode),
        .byteMode(byteMode), .srcAReg(srcAReg), .srcBReg(srcBReg), .srcAFromMem(srcAFromMem),
        .srcBFromMem(srcBFromMem), .memDataA(memDataA), .memDataB(memDataB), .literal(literal),
        .dstReg(dstReg), .dstToMem(dstToMem), .flagsWrite(flagsWrite), .result(result),
        .resultHigh(resultHigh), .memWrite(memWrite), .memWriteByte(memWriteByte), .done(done),
        .busy(busy), .alu_status_register(alu_status_register));
    amd_mem_model mem (.clk(clk), .rst_b(rst_b), .memWrite(memWrite),
        .memWriteByte(memWriteByte), .result(result), .storedWord(storedWord),
        .writeCount(writeCount));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (nErrors == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One issue pulse, then a bounded wait; lat counts edges after the take
    task automatic run(input amd_op_type o, input amd_mul_type m, input logic bm,
        input logic [15:0] a, input logic [15:0] b, input logic [4:0] lit,
        input logic toMem, input logic [3:0] d);
        @(posedge clk);
        {op, mulMode, byteMode} <= {o, m, bm};
        {memDataA, memDataB, literal, dstToMem, dstReg} <= {a, b, lit, toMem, d};
        issue <= 1'b1;
        @(posedge clk);
        issue <= 1'b0;
        for (lat = 0; lat < 40; lat++) begin
            #1;
            if (done === 1'b1) break;
            @(posedge clk);
        end
        if (lat == 40) chk("done", 1, 0);
    endtask
    // Timeout: far above the hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nErrors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        chk("status", 5'h00, alu_status_register);
        repeat (3) @(posedge clk);
        run(AMD_OP_ADD, AMD_MUL_SS, 0, 16'h7fff, 16'h0001, 0, 0, 0);
        addLat = lat;
        chk("add", 16'h8000, result);
        chk("status", 5'h1c, alu_status_register);
        run(AMD_OP_SUB, AMD_MUL_SS, 0, 16'h0005, 16'h0005, 0, 0, 0);
        chk("status", 5'h13, alu_status_register);
        run(AMD_OP_SUB, AMD_MUL_SS, 0, 16'h0000, 16'h0001, 0, 0, 0);
        chk("sub", 32'h2000ffff, {alu_status_register, 11'h000, result});
        run(AMD_OP_ADD, AMD_MUL_SS, 1, 16'h12ff, 16'h0001, 0, 0, 0);
        chk("addb", 32'h98000000, {alu_status_register, 11'h000, result});
        run(AMD_OP_ADD, AMD_MUL_SS, 1, 16'h007f, 16'h0001, 0, 0, 0);
        chk("addb", 32'he0000080, {alu_status_register, 11'h000, result});
        run(AMD_OP_AND, AMD_MUL_SS, 0, 16'hf0f0, 16'h0ff0, 0, 0, 0);
        chk("and", 16'h00f0, result);
        run(AMD_OP_IOR, AMD_MUL_SS, 0, 16'hf0f0, 16'h0ff0, 0, 0, 0);
        chk("ior", 16'hfff0, result);
        run(AMD_OP_XOR, AMD_MUL_SS, 1, 16'hf0f0, 16'h0ff0, 0, 0, 0);
        chk("xorb", 16'h0000, result);
        run(AMD_OP_SHL, AMD_MUL_SS, 0, 16'h8001, 0, 0, 0, 0);
        chk("shl", 17'h10002, {alu_status_register[0], result});
        run(AMD_OP_LSR, AMD_MUL_SS, 0, 16'h8001, 0, 0, 0, 0);
        chk("lsr", 17'h14000, {alu_status_register[0], result});
        run(AMD_OP_ASR, AMD_MUL_SS, 0, 16'h8001, 0, 0, 0, 0);
        chk("asr", 17'h1c000, {alu_status_register[0], result});
        // Multiplier sign mixes
        run(AMD_OP_MUL, AMD_MUL_SS, 0, 16'hfffe, 16'h0003, 0, 0, 1);
        chk("mulss", 32'hfffffffa, {resultHigh, result});
        run(AMD_OP_MUL, AMD_MUL_UU, 0, 16'hfffe, 16'h0003, 0, 0, 1);
        chk("muluu", 32'h0002fffa, {resultHigh, result});
        run(AMD_OP_MUL, AMD_MUL_US, 0, 16'hffff, 16'hffff, 0, 0, 1);
        chk("mulus", 32'hffff0001, {resultHigh, result});
        run(AMD_OP_MUL, AMD_MUL_SL, 0, 16'hfffe, 0, 5'h1f, 0, 1);
        chk("mulsl", 32'hffffffc2, {resultHigh, result});
        run(AMD_OP_MUL, AMD_MUL_UL, 0, 16'hfffe, 0, 5'h1f, 0, 1);
        chk("mulul", 32'h001effc2, {resultHigh, result});
        run(AMD_OP_MUL, AMD_MUL_BB, 0, 16'h12ff, 16'h34ff, 0, 0, 1);
        chk("mulbb", 32'h0000fe01, {resultHigh, result});
        // Divides take seventeen cycles more than a plain operation
        run(AMD_OP_DIVU, AMD_MUL_SS, 0, 16'h0064, 16'h0007, 0, 0, 2);
        chk("divu", 32'h000e0002, {result, resultHigh});
        chk("divlat", addLat + 17, lat);
        run(AMD_OP_DIVS, AMD_MUL_SS, 0, 16'hfff9, 16'h0002, 0, 0, 2);
        chk("divs", 32'hfffdffff, {result, resultHigh});
        run(AMD_OP_DIVU, AMD_MUL_SS, 0, 16'h0009, 16'h0000, 0, 0, 2);
        chk("div0", 1, alu_status_register[3]);
        // Register and memory destinations, byte write keeps the high byte
        run(AMD_OP_ADD, AMD_MUL_SS, 0, 16'h1234, 0, 0, 0, 4'hf);
        run(AMD_OP_ADD, AMD_MUL_SS, 1, 16'h00ff, 16'h0001, 0, 0, 4'hf);
        chk("nostore", 0, writeCount);
        run(AMD_OP_ADD, AMD_MUL_SS, 0, 16'h1201, 16'h0002, 0, 1, 0);
        run(AMD_OP_ADD, AMD_MUL_SS, 1, 16'h00fe, 16'h0001, 0, 1, 0);
        chk("store", 32'h00011203, {writeCount, storedWord});
        @(posedge clk);
        #1;
        chk("storeb", 32'h000212ff, {writeCount, storedWord});
        @(posedge clk) {srcAFromMem, srcAReg} <= 5'h0f;
        run(AMD_OP_ADD, AMD_MUL_SS, 0, 0, 16'h0000, 0, 0, 0);
        chk("reg15", 16'h1200, result);
        @(posedge clk) srcAReg <= 4'h1;
        run(AMD_OP_ADD, AMD_MUL_SS, 0, 0, 16'h0001, 0, 0, 0);
        chk("reg1", 16'hfe02, result);
        wrap_up();
    end
endmodule
`default_nettype wire
